// >>> hdl/ulm_delay.sv
// bit-time delay counter used for rs-485 setup and turn-around
`timescale 1ns/100ps
`default_nettype none
module ulm_delay (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [3:0] bits,
  input wire logic bit_tick,
  output logic done
);
  logic [3:0] cnt_ff; // bit times still to wait
  logic run_ff; // counting
  logic [3:0] nxt_cnt;
  logic nxt_run;
  // next values: zero length finishes at once
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    done = 1'b0;
    if (start) begin
      nxt_cnt = bits;
      nxt_run = (bits != 4'h0);
      done = (bits == 4'h0);
    end else if (run_ff && bit_tick) begin
      if (cnt_ff == 4'h1) begin
        nxt_run = 1'b0;
        done = 1'b1;
      end
      nxt_cnt = cnt_ff - 4'h1;
    end
    if (!rst_n) begin
      nxt_cnt = 4'h0;
      nxt_run = 1'b0;
    end
  end
  // register only
  always_ff @(posedge mclk) begin
    cnt_ff <= nxt_cnt;
    run_ff <= nxt_run;
  end
endmodule : ulm_delay
`default_nettype wire

// >>> hdl/ulm_pkg.sv
// shared constants for the uart line-mode and sleep block
package ulm_pkg;
  // clock rate and sizes
  localparam int unsigned CLK_HZ = 20000000;
  localparam int DIV_W = 16;
  localparam int DLY_W = 4;
  // feature_ctrl_reg field
  localparam int FC_DIR_BIT = 3;
  // setup_hysteresis_reg fields
  localparam int SH_SETUP_HI = 7;
  localparam int SH_SETUP_LO = 4;
  localparam int SH_TURN_HI = 3;
  localparam int SH_TURN_LO = 0;
  // modem_status_reg enhanced fields
  localparam int MS_MDROP_BIT = 6;
  localparam int MS_IR11_BIT = 7;
  // enhanced_func_reg fields
  localparam int EF_ENH_BIT = 4;
  localparam int EF_SCD_BIT = 5;
  // line_ctrl_reg parity field
  localparam int LC_PAR_HI = 5;
  localparam int LC_PAR_LO = 3;
  localparam logic [2:0] PAR_FORCE0 = 3'h7;
  // special_func_reg field
  localparam int SF_ADDR_BIT = 7;
  // modem_ctrl_reg fields
  localparam int MC_LOOP_BIT = 4;
  localparam int MC_IR_BIT = 6;
  // int_enable_reg field
  localparam int IE_SLEEP_BIT = 4;
  // fifo_ctrl_reg field
  localparam int FF_WAKE_BIT = 3;
  // infrared pulse widths in sixteenths of a bit
  localparam logic [3:0] IR10_TICKS = 4'h3;
  localparam logic [3:0] IR11_TICKS = 4'h4;
  // last oversample tick of a bit
  localparam logic [3:0] TICK_LAST = 4'hf;
  // direction-control phases
  typedef enum logic [1:0] {
    ULM_DIR_IDLE = 2'b00,
    ULM_DIR_SETUP = 2'b01,
    ULM_DIR_SEND = 2'b10,
    ULM_DIR_TURN = 2'b11
  } ulm_dir_t;
endpackage : ulm_pkg

// >>> hdl/ulm_sync.sv
// two-flop synchroniser for a single pin level
`timescale 1ns/100ps
`default_nettype none
module ulm_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic rst_val,
  input wire logic d,
  output logic q
);
  logic meta_ff; // first stage, read only by second stage
  logic q_ff; // settled level
  logic nxt_meta;
  logic nxt_q;
  // next values: reset loads the pin's idle level
  always_comb begin
    nxt_meta = rst_n ? d : rst_val;
    nxt_q = rst_n ? meta_ff : rst_val;
  end
  // register only (synchronous reset)
  always_ff @(posedge mclk) begin
    meta_ff <= nxt_meta;
    q_ff <= nxt_q;
  end
  assign q = q_ff;
endmodule : ulm_sync
`default_nettype wire

// >>> hdl/ulm_top.sv
// line-mode logic: rs-485 direction, multidrop, infrared, sleep, loopback
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - direction bit turns rts into transceiver enable
// - rts off when idle, on when loaded
// - tx empty event follows shift register empty in direction mode only
// - setup delay 0-15 bits before data
// - turn-around delay 0-15 bits before rts release
// - multidrop on, no char detect: normal mode
// - disabled receiver drops data, keeps address with error
// - enabled receiver keeps data, flags every address
// - auto detect uses second stop character address
// - auto mode drops foreign addresses, and data while disabled
// - matching address enables receiver, stored, flagged
// - foreign address disables, matching one stored again
// - address flag sends ninth bit one, self-clears
// - ir mode: 3/16 high pulse per zero
// - ir 1.1: 1/4 high pulse per zero
// - ir receive idles low, pulse gives zero bit
// - register sleep only when all conditions hold
// - oscillator output stopped while asleep
// - wake on start edge, write, modem change
// - sleep pin waits shifters idle; release wakes only with the sleep enable bit clear or a wake event
// - wake-up interrupt gated by fifo control bit
// - loopback routes tx to rx, masks modem pins
module ulm_top
  import ulm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] feature_ctrl_reg,
  input wire logic [7:0] setup_hysteresis_reg,
  input wire logic [7:0] modem_status_reg,
  input wire logic [7:0] enhanced_func_reg,
  input wire logic [7:0] line_ctrl_reg,
  input wire logic [7:0] modem_ctrl_reg,
  input wire logic [7:0] int_enable_reg,
  input wire logic [7:0] fifo_ctrl_reg,
  input wire logic [7:0] second_stop_char_reg,
  input wire logic [ulm_pkg::DIV_W-1:0] divisor,
  input wire logic sfr_addr_set,
  input wire logic tick16,
  input wire logic thr_write,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_empty,
  input wire logic tx_shift_busy,
  input wire logic tx_shift_bit,
  input wire logic tx_data_start,
  input wire logic rx_shift_busy,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_par,
  input wire logic int_pending,
  input wire logic rts_user,
  input wire logic dtr_user,
  input wire logic rx_pin,
  input wire logic cts_n_pin,
  input wire logic dsr_n_pin,
  input wire logic cd_n_pin,
  input wire logic ri_n_pin,
  input wire logic sleep_pin,
  output logic tx_pin,
  output logic rts_n_pin,
  output logic dtr_n_pin,
  output logic tx_hold_data,
  output logic tx_ninth_bit,
  output logic sfr_addr_bit,
  output logic rx_serial,
  output logic [3:0] modem_in,
  output logic rx_push,
  output logic [7:0] rx_push_data,
  output logic rx_push_perr,
  output logic lsr_int,
  output logic tx_empty_evt,
  output logic rx_enabled,
  output logic asleep,
  output logic osc_run,
  output logic wake_int
);
  import ulm_pkg::*;

  // mode decode
  logic enh; // enhanced functions on
  logic dir_mode; // rs-485 direction control
  logic mdrop; // any multidrop receive mode
  logic auto_addr; // automatic address detection
  logic ir_on; // infrared codec on
  logic ir11; // 1.1 timing
  logic loop_on; // internal loopback
  assign enh = enhanced_func_reg[EF_ENH_BIT];
  assign dir_mode = feature_ctrl_reg[FC_DIR_BIT];
  assign mdrop = enh && modem_status_reg[MS_MDROP_BIT];
  assign auto_addr = mdrop && enhanced_func_reg[EF_SCD_BIT];
  assign ir_on = modem_ctrl_reg[MC_IR_BIT];
  assign ir11 = ir_on && enh && modem_status_reg[MS_IR11_BIT];
  assign loop_on = modem_ctrl_reg[MC_LOOP_BIT];

  // pin synchronisers; rx idles low in infrared mode after reset
  logic rx_s;
  logic cts_s;
  logic dsr_s;
  logic cd_s;
  logic ri_s;
  logic sleep_s;
  ulm_sync u_rx (.mclk(mclk), .rst_n(rst_n), .rst_val(1'b0), .d(rx_pin), .q(rx_s));
  ulm_sync u_cts (.mclk(mclk), .rst_n(rst_n), .rst_val(1'b1), .d(cts_n_pin), .q(cts_s));
  ulm_sync u_dsr (.mclk(mclk), .rst_n(rst_n), .rst_val(1'b1), .d(dsr_n_pin), .q(dsr_s));
  ulm_sync u_cd (.mclk(mclk), .rst_n(rst_n), .rst_val(1'b1), .d(cd_n_pin), .q(cd_s));
  ulm_sync u_ri (.mclk(mclk), .rst_n(rst_n), .rst_val(1'b1), .d(ri_n_pin), .q(ri_s));
  ulm_sync u_slp (.mclk(mclk), .rst_n(rst_n), .rst_val(1'b0), .d(sleep_pin), .q(sleep_s));

  // bit-time tick from the 16x oversample enable
  logic [3:0] tick_cnt_ff; // sixteenths within a bit
  logic [3:0] nxt_tick_cnt;
  logic bit_tick;
  assign bit_tick = tick16 && (tick_cnt_ff == TICK_LAST);

  // rs-485 direction state
  ulm_dir_t dir_ff; // direction phase
  ulm_dir_t nxt_dir;
  logic setup_done;
  logic turn_done;
  logic setup_go;
  logic turn_go;
  logic tx_busy_d_ff; // last cycle's shifter busy
  logic nxt_tx_busy_d;

  // direction delay counters
  ulm_delay u_setup (.mclk(mclk), .rst_n(rst_n), .start(setup_go),
    .bits(setup_hysteresis_reg[SH_SETUP_HI:SH_SETUP_LO]), .bit_tick(bit_tick),
    .done(setup_done));
  ulm_delay u_turn (.mclk(mclk), .rst_n(rst_n), .start(turn_go),
    .bits(setup_hysteresis_reg[SH_TURN_HI:SH_TURN_LO]), .bit_tick(bit_tick),
    .done(turn_done));

  // direction phase next state
  always_comb begin
    nxt_dir = dir_ff;
    setup_go = 1'b0;
    turn_go = 1'b0;
    nxt_tx_busy_d = tx_shift_busy;
    nxt_tick_cnt = tick16 ? tick_cnt_ff + 4'h1 : tick_cnt_ff;
    unique case (dir_ff)
      ULM_DIR_IDLE: begin
        // rts goes on once data reaches the fifo
        if (dir_mode && (thr_write || !tx_fifo_empty)) begin
          setup_go = 1'b1;
          nxt_dir = setup_done ? ULM_DIR_SEND : ULM_DIR_SETUP; // zero delay skips setup
        end
      end
      ULM_DIR_SETUP: begin
        if (setup_done) begin
          nxt_dir = ULM_DIR_SEND;
        end
      end
      ULM_DIR_SEND: begin
        // line idle after last bit and nothing left queued
        if (!tx_shift_busy && tx_fifo_empty && !thr_write) begin
          turn_go = 1'b1;
          nxt_dir = turn_done ? ULM_DIR_IDLE : ULM_DIR_TURN; // zero delay drops rts at once
        end
      end
      ULM_DIR_TURN: begin
        if (thr_write) begin
          nxt_dir = ULM_DIR_SEND; // new data keeps the driver on
        end else if (turn_done) begin
          nxt_dir = ULM_DIR_IDLE;
        end
      end
    endcase
    if (tx_data_start || setup_go || turn_go) begin
      nxt_tick_cnt = 4'h0; // whole bit times from frame or delay start
    end
    if (!dir_mode || !rst_n) begin
      nxt_dir = ULM_DIR_IDLE;
    end
    if (!rst_n) begin
      nxt_tick_cnt = 4'h0;
      nxt_tx_busy_d = 1'b0;
    end
  end
  // direction registers
  always_ff @(posedge mclk) begin
    dir_ff <= nxt_dir;
    tick_cnt_ff <= nxt_tick_cnt;
    tx_busy_d_ff <= nxt_tx_busy_d;
  end

  // hold data back from the shifter during setup delay
  logic nxt_hold;
  logic hold_ff;
  // rts, dtr, tx and loopback routing
  logic nxt_rts_n;
  logic nxt_dtr_n;
  logic nxt_tx;
  logic nxt_rx_serial;
  logic [3:0] nxt_modem_in;
  logic nxt_empty_evt;
  logic rts_n_ff;
  logic dtr_n_ff;
  logic tx_ff;
  logic rx_serial_ff;
  logic [3:0] modem_in_ff;
  logic empty_evt_ff;

  // infrared pulse and decode
  logic [3:0] ir_tx_cnt_ff; // sixteenths into current tx bit
  logic [3:0] nxt_ir_tx_cnt;
  logic ir_pulse;
  logic ir_rx_bit;
  assign ir_pulse = !tx_shift_bit && !tx_data_start &&
    (ir_tx_cnt_ff < (ir11 ? IR11_TICKS : IR10_TICKS));
  assign ir_rx_bit = !rx_s; // light pulse becomes a zero bit

  // line outputs next values
  always_comb begin
    nxt_hold = (dir_ff == ULM_DIR_IDLE && dir_mode) || dir_ff == ULM_DIR_SETUP;
    nxt_ir_tx_cnt = ir_tx_cnt_ff;
    if (tx_data_start) begin
      nxt_ir_tx_cnt = 4'h0;
    end else if (tick16) begin
      nxt_ir_tx_cnt = ir_tx_cnt_ff + 4'h1;
    end
    // rts: direction control overrides the user level
    if (loop_on) begin
      nxt_rts_n = 1'b1;
    end else if (dir_mode) begin
      nxt_rts_n = (dir_ff == ULM_DIR_IDLE);
    end else begin
      nxt_rts_n = !rts_user;
    end
    nxt_dtr_n = loop_on ? 1'b1 : !dtr_user;
    // tx pin: mark in loopback, pulses in infrared
    if (loop_on) begin
      nxt_tx = ir_on ? 1'b0 : 1'b1;
    end else if (ir_on) begin
      nxt_tx = ir_pulse && tx_shift_busy;
    end else begin
      nxt_tx = tx_shift_busy ? tx_shift_bit : 1'b1;
    end
    // receive stream
    if (loop_on) begin
      nxt_rx_serial = tx_shift_busy ? tx_shift_bit : 1'b1;
    end else begin
      nxt_rx_serial = ir_on ? ir_rx_bit : rx_s;
    end
    // modem inputs frozen at inactive in loopback
    nxt_modem_in = loop_on ? 4'hf : {ri_s, cd_s, dsr_s, cts_s};
    // empty event: shifter drain in direction mode, never otherwise
    if (dir_mode) begin
      nxt_empty_evt = tx_busy_d_ff && !tx_shift_busy && tx_fifo_empty;
    end else begin
      nxt_empty_evt = 1'b0;
    end
    if (!rst_n) begin
      nxt_hold = 1'b0;
      nxt_ir_tx_cnt = 4'h0;
      nxt_rts_n = 1'b1;
      nxt_dtr_n = 1'b1;
      nxt_tx = 1'b1;
      nxt_rx_serial = 1'b1;
      nxt_modem_in = 4'hf;
      nxt_empty_evt = 1'b0;
    end
  end
  // line output registers
  always_ff @(posedge mclk) begin
    hold_ff <= nxt_hold;
    ir_tx_cnt_ff <= nxt_ir_tx_cnt;
    rts_n_ff <= nxt_rts_n;
    dtr_n_ff <= nxt_dtr_n;
    tx_ff <= nxt_tx;
    rx_serial_ff <= nxt_rx_serial;
    modem_in_ff <= nxt_modem_in;
    empty_evt_ff <= nxt_empty_evt;
  end

  // multidrop receive and address flag
  logic rx_en_ff; // receiver enabled
  logic addr_flag_ff; // next written byte is an address
  logic ninth_ff;
  logic push_ff;
  logic [7:0] push_data_ff;
  logic push_perr_ff;
  logic lsr_ff;
  logic nxt_rx_en;
  logic nxt_addr_flag;
  logic nxt_ninth;
  logic nxt_push;
  logic [7:0] nxt_push_data;
  logic nxt_push_perr;
  logic nxt_lsr;
  logic addr_hit;
  assign addr_hit = (rx_char == second_stop_char_reg);

  // multidrop next values
  always_comb begin
    nxt_rx_en = rx_en_ff;
    nxt_addr_flag = addr_flag_ff;
    nxt_ninth = ninth_ff;
    nxt_push = 1'b0;
    nxt_push_data = rx_char;
    nxt_push_perr = rx_char_par;
    nxt_lsr = 1'b0;
    // set wins: software arming coincident with a write arms the next byte
    if (thr_write) begin
      nxt_ninth = addr_flag_ff;
      nxt_addr_flag = 1'b0; // self-clearing
    end
    if (sfr_addr_set) begin
      nxt_addr_flag = 1'b1;
    end
    if (rx_char_valid) begin
      if (!mdrop) begin
        nxt_push = 1'b1;
        nxt_push_perr = 1'b0;
      end else if (!auto_addr) begin
        // software steers enable; hardware only filters
        if (rx_char_par) begin
          nxt_push = 1'b1;
          nxt_lsr = 1'b1;
        end else begin
          nxt_push = rx_en_ff;
        end
      end else if (rx_char_par) begin
        if (addr_hit) begin
          nxt_rx_en = 1'b1;
          nxt_push = 1'b1;
          nxt_lsr = 1'b1;
        end else begin
          nxt_rx_en = 1'b0;
        end
      end else begin
        nxt_push = rx_en_ff;
      end
    end
    if (!rst_n) begin
      nxt_rx_en = 1'b0;
      nxt_addr_flag = 1'b0;
      nxt_ninth = 1'b0;
      nxt_push = 1'b0;
      nxt_push_data = 8'h00;
      nxt_push_perr = 1'b0;
      nxt_lsr = 1'b0;
    end
  end
  // multidrop registers
  always_ff @(posedge mclk) begin
    rx_en_ff <= nxt_rx_en;
    addr_flag_ff <= nxt_addr_flag;
    ninth_ff <= nxt_ninth;
    push_ff <= nxt_push;
    push_data_ff <= nxt_push_data;
    push_perr_ff <= nxt_push_perr;
    lsr_ff <= nxt_lsr;
  end

  // sleep and wake
  logic asleep_ff;
  logic osc_ff;
  logic wake_int_ff;
  logic rx_prev_ff; // delayed synced rx for start-edge detect
  logic [3:0] modem_prev_ff;
  logic nxt_asleep;
  logic nxt_wake_int;
  logic nxt_rx_prev;
  logic [3:0] nxt_modem_prev;
  logic rx_idle_ok;
  logic reg_sleep_ok;
  logic pin_sleep_ok;
  logic wake_evt;
  assign rx_idle_ok = ir_on ? !rx_s : rx_s;
  assign reg_sleep_ok = !int_pending && int_enable_reg[IE_SLEEP_BIT] &&
    (modem_status_reg[3:0] == 4'h0) && rx_idle_ok && (divisor != '0) &&
    tx_fifo_empty && rx_fifo_empty;
  assign pin_sleep_ok = sleep_s && !tx_shift_busy && !rx_shift_busy;
  assign wake_evt = (rx_prev_ff && !rx_s && !ir_on) || (ir_on && rx_s) || thr_write ||
    (!loop_on && ({ri_s, cd_s, dsr_s, cts_s} != modem_prev_ff));

  // sleep next values
  always_comb begin
    nxt_asleep = asleep_ff;
    nxt_wake_int = wake_int_ff;
    nxt_rx_prev = rx_s;
    nxt_modem_prev = {ri_s, cd_s, dsr_s, cts_s};
    if (asleep_ff) begin
      if (sleep_s) begin
        nxt_asleep = 1'b1; // only pin release wakes
      end else if (wake_evt || !int_enable_reg[IE_SLEEP_BIT]) begin
        nxt_asleep = 1'b0;
        nxt_wake_int = fifo_ctrl_reg[FF_WAKE_BIT];
      end
    end else if (pin_sleep_ok || (reg_sleep_ok && !wake_evt)) begin
      nxt_asleep = 1'b1;
    end
    if (!fifo_ctrl_reg[FF_WAKE_BIT] || (!int_pending && !nxt_asleep && wake_int_ff)) begin
      nxt_wake_int = 1'b0;
    end
    if (!rst_n) begin
      nxt_asleep = 1'b0;
      nxt_wake_int = 1'b0;
      nxt_rx_prev = 1'b1;
      nxt_modem_prev = 4'hf;
    end
  end
  // sleep registers; oscillator runs whenever awake
  always_ff @(posedge mclk) begin
    asleep_ff <= nxt_asleep;
    osc_ff <= !nxt_asleep;
    wake_int_ff <= nxt_wake_int;
    rx_prev_ff <= nxt_rx_prev;
    modem_prev_ff <= nxt_modem_prev;
  end

  // outputs straight from flops
  assign tx_pin = tx_ff;
  assign rts_n_pin = rts_n_ff;
  assign dtr_n_pin = dtr_n_ff;
  assign tx_hold_data = hold_ff;
  assign tx_ninth_bit = ninth_ff;
  assign sfr_addr_bit = addr_flag_ff;
  assign rx_serial = rx_serial_ff;
  assign modem_in = modem_in_ff;
  assign rx_push = push_ff;
  assign rx_push_data = push_data_ff;
  assign rx_push_perr = push_perr_ff;
  assign lsr_int = lsr_ff;
  assign tx_empty_evt = empty_evt_ff;
  assign rx_enabled = rx_en_ff;
  assign asleep = asleep_ff;
  assign osc_run = osc_ff;
  assign wake_int = wake_int_ff;
endmodule : ulm_top
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the line-mode block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import ulm_pkg::*;
  logic mclk, rst_n, sfr_addr_set, tick16, thr_write, tx_fifo_empty, rx_fifo_empty;
  logic tx_shift_busy, tx_shift_bit, tx_data_start, rx_shift_busy, rx_char_valid;
  logic rx_char_par, int_pending, rts_user, dtr_user, rx_pin, cts_n_pin, dsr_n_pin;
  logic cd_n_pin, ri_n_pin, sleep_pin, tx_pin, rts_n_pin, dtr_n_pin, tx_hold_data;
  logic tx_ninth_bit, sfr_addr_bit, rx_serial, rx_push, rx_push_perr, lsr_int;
  logic tx_empty_evt, rx_enabled, asleep, osc_run, wake_int, go;
  logic [7:0] feature_ctrl_reg, setup_hysteresis_reg, modem_status_reg, enhanced_func_reg;
  logic [7:0] line_ctrl_reg, modem_ctrl_reg, int_enable_reg, fifo_ctrl_reg;
  logic [7:0] second_stop_char_reg, rx_char, rx_push_data, pw;
  logic [3:0] modem_in;
  logic [DIV_W-1:0] divisor;
  int mismatches, checks_done;
  ulm_top i_ulm_top (.*);
  ulm_station i_ulm_station (.mclk(mclk), .ir(modem_ctrl_reg[6]), .start(go),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .pulse_w(pw));
  // free-running 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // one-cycle strobe launched at a falling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
  endtask : pulse
  // bounded wait; a wait that runs out counts as a mismatch
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    chk(s, v);
  endtask : wait_lvl
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_loop;
    modem_ctrl_reg = 8'h10;
    rts_user = 1'b1;
    dtr_user = 1'b1;
    tx_shift_bit = 1'b0;
    tx_shift_busy = 1'b1;
    cyc(3);
    chk({tx_pin, rts_n_pin, dtr_n_pin, rx_serial}, 4'he);
    tx_shift_bit = 1'b1;
    cyc(2);
    chk(rx_serial, 1'b1);
    tx_shift_busy = 1'b0;
    modem_ctrl_reg = 8'h00;
    cyc(2);
    chk({rts_n_pin, dtr_n_pin}, 2'b00);
  endtask : t_loop
  // one direction-mode frame; windows allow for bit alignment
  task automatic dir_run(input logic [7:0] sh, input int s_lo, input int t_lo);
    int n;
    setup_hysteresis_reg = sh;
    tx_fifo_empty = 1'b0;
    pulse(thr_write);
    wait_lvl(rts_n_pin, 1'b0, 4, n);
    wait_lvl(tx_hold_data, 1'b0, 40, n);
    chk(n inside {[s_lo:s_lo + 5]}, 1'b1);
    tx_shift_busy = 1'b1;
    pulse(tx_data_start);
    tx_fifo_empty = 1'b1;
    cyc(20);
    tx_shift_busy = 1'b0;
    wait_lvl(tx_empty_evt, 1'b1, 4, n);
    wait_lvl(rts_n_pin, 1'b1, 60, n);
    chk(n inside {[t_lo:t_lo + 5]}, 1'b1);
  endtask : dir_run
  task automatic t_dir;
    feature_ctrl_reg = 8'h08;
    cyc(3);
    chk(rts_n_pin, 1'b1);
    dir_run(8'h23, 29, 45);
    dir_run(8'h00, 0, 0);
    feature_ctrl_reg = 8'h00;
    rts_user = 1'b0;
    cyc(2);
  endtask : t_dir
  task automatic t_ninth;
    pulse(sfr_addr_set);
    chk(sfr_addr_bit, 1'b1);
    cyc(1);
    pulse(thr_write);
    chk({tx_ninth_bit, sfr_addr_bit}, 2'b10);
    cyc(1);
    pulse(thr_write);
    chk(tx_ninth_bit, 1'b0);
  endtask : t_ninth
  task automatic rx_byte(input logic [7:0] c, input logic p, input logic psh, input logic en);
    rx_char = c;
    rx_char_par = p;
    pulse(rx_char_valid);
    chk({rx_push, lsr_int, rx_enabled}, {psh, psh & p, en});
    if (psh) chk({rx_push_data, rx_push_perr}, {c, p});
    cyc(1);
  endtask : rx_byte
  task automatic t_mdrop;
    modem_status_reg = 8'h40;
    enhanced_func_reg = 8'h10;
    line_ctrl_reg = {2'b00, PAR_FORCE0, 3'h0};
    cyc(1);
    rx_byte(8'h21, 1'b0, 1'b0, 1'b0);
    rx_byte(8'h42, 1'b1, 1'b1, 1'b0);
    enhanced_func_reg = 8'h30;
    second_stop_char_reg = 8'h5a;
    cyc(1);
    rx_byte(8'h5a, 1'b0, 1'b0, 1'b0);
    rx_byte(8'h11, 1'b1, 1'b0, 1'b0);
    rx_byte(8'h5a, 1'b1, 1'b1, 1'b1);
    rx_byte(8'h77, 1'b0, 1'b1, 1'b1);
    rx_byte(8'h5a, 1'b1, 1'b1, 1'b1);
    rx_byte(8'h12, 1'b1, 1'b0, 1'b0);
    rx_byte(8'h33, 1'b0, 1'b0, 1'b0);
    {modem_status_reg, enhanced_func_reg} = 16'h0000;
  endtask : t_mdrop
  // one zero bit through the encoder, high time read by the station
  task automatic ir_run(input logic [7:0] w);
    cyc(4);
    chk(rx_serial, 1'b1);
    tx_shift_busy = 1'b1;
    tx_shift_bit = 1'b0;
    pulse(tx_data_start);
    cyc(15);
    tx_shift_bit = 1'b1;
    cyc(20);
    tx_shift_busy = 1'b0;
    chk(pw, w);
  endtask : ir_run
  task automatic t_ir;
    modem_ctrl_reg = 8'h40;
    ir_run({4'h0, IR10_TICKS});
    modem_status_reg = 8'h80;
    enhanced_func_reg = 8'h10;
    ir_run({4'h0, IR11_TICKS});
    {modem_ctrl_reg, modem_status_reg, enhanced_func_reg} = 24'h000000;
    cyc(4);
  endtask : t_ir
  task automatic t_sleep;
    int n;
    int_pending = 1'b1;
    int_enable_reg = 8'h10;
    cyc(6);
    chk(asleep, 1'b0);
    int_pending = 1'b0;
    divisor = '0;
    cyc(6);
    chk(asleep, 1'b0);
    divisor = 16'h0001;
    wait_lvl(asleep, 1'b1, 8, n);
    chk(osc_run, 1'b0);
    fifo_ctrl_reg = 8'h08;
    cts_n_pin = 1'b0;
    wait_lvl(asleep, 1'b0, 8, n);
    wait_lvl(wake_int, 1'b1, 4, n);
    wait_lvl(asleep, 1'b1, 12, n);
    chk(modem_in, 4'he);
    fifo_ctrl_reg = 8'h00;
    pulse(go);
    wait_lvl(asleep, 1'b0, 8, n);
    wait_lvl(asleep, 1'b1, 40, n);
    pulse(thr_write);
    wait_lvl(asleep, 1'b0, 4, n);
    int_enable_reg = 8'h00;
    cyc(20);
    chk(asleep, 1'b0);
    tx_shift_busy = 1'b1;
    sleep_pin = 1'b1;
    cyc(8);
    chk(asleep, 1'b0);
    tx_shift_busy = 1'b0;
    tx_fifo_empty = 1'b0;
    wait_lvl(asleep, 1'b1, 8, n);
    pulse(thr_write);
    cyc(4);
    chk(asleep, 1'b1);
    sleep_pin = 1'b0;
    wait_lvl(asleep, 1'b0, 8, n);
  endtask : t_sleep
  // main sequence
  initial begin
    {feature_ctrl_reg, setup_hysteresis_reg, modem_status_reg, enhanced_func_reg} = '0;
    {line_ctrl_reg, modem_ctrl_reg, int_enable_reg, fifo_ctrl_reg} = '0;
    {second_stop_char_reg, rx_char, divisor} = '0;
    {rst_n, sfr_addr_set, thr_write, tx_shift_busy, tx_data_start, rx_shift_busy} = '0;
    {rx_char_valid, rx_char_par, int_pending, rts_user, dtr_user, sleep_pin, go} = '0;
    {tick16, tx_fifo_empty, rx_fifo_empty, cts_n_pin, dsr_n_pin, cd_n_pin} = '1;
    {ri_n_pin, tx_shift_bit} = '1;
    mismatches = 0;
    checks_done = 0;
    cyc(10);
    rst_n = 1'b1;
    cyc(2);
    t_loop();
    t_dir();
    t_ninth();
    t_mdrop();
    t_ir();
    t_sleep();
    tally_and_finish();
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

// >>> sim/ulm_monitor.sv
// port checker for the line-mode block
`timescale 1ns/100ps
`default_nettype none
module ulm_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] feature_ctrl_reg,
  input wire logic [7:0] modem_status_reg,
  input wire logic [7:0] enhanced_func_reg,
  input wire logic [7:0] modem_ctrl_reg,
  input wire logic [7:0] int_enable_reg,
  input wire logic [7:0] fifo_ctrl_reg,
  input wire logic [7:0] second_stop_char_reg,
  input wire logic sfr_addr_set,
  input wire logic thr_write,
  input wire logic tx_shift_busy,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_char_par,
  input wire logic int_pending,
  input wire logic sleep_pin,
  input wire logic tx_pin,
  input wire logic rts_n_pin,
  input wire logic dtr_n_pin,
  input wire logic tx_ninth_bit,
  input wire logic sfr_addr_bit,
  input wire logic rx_push,
  input wire logic rx_push_perr,
  input wire logic lsr_int,
  input wire logic tx_empty_evt,
  input wire logic rx_enabled,
  input wire logic asleep,
  input wire logic osc_run,
  input wire logic wake_int
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic md; // multidrop selected with enhanced functions
  logic [4:0] pin_hist_ff; // recent sleep pin levels, seen as high in reset
  assign md = modem_status_reg[6] && enhanced_func_reg[4];
  // history keeps pin-driven sleep out of the register-sleep check
  always_ff @(posedge mclk) begin
    if (!rst_n) pin_hist_ff <= 5'h1f;
    else pin_hist_ff <= {pin_hist_ff[3:0], sleep_pin};
  end
  sequence s_load;
    feature_ctrl_reg[3] && !modem_ctrl_reg[4] && thr_write && rts_n_pin;
  endsequence
  sequence s_addr_send;
    thr_write && sfr_addr_bit && !sfr_addr_set;
  endsequence
  property p_loop_pins;
    modem_ctrl_reg[4] && $past(modem_ctrl_reg[4]) && !modem_ctrl_reg[6]
      |-> tx_pin && rts_n_pin && dtr_n_pin;
  endproperty
  a_loop_pins: assert property (p_loop_pins) else $error("loopback pins wrong");
  property p_dir_on;
    s_load |-> ##[1:2] !rts_n_pin;
  endproperty
  a_dir_on: assert property (p_dir_on) else $error("rts not asserted on load");
  property p_empty_evt;
    tx_empty_evt |-> $past(feature_ctrl_reg[3]) && !$past(tx_shift_busy);
  endproperty
  a_empty_evt: assert property (p_empty_evt) else $error("early empty event");
  property p_sleep_osc;
    asleep && $past(asleep) |-> !osc_run;
  endproperty
  a_sleep_osc: assert property (p_sleep_osc) else $error("clock runs in sleep");
  property p_sleep_gate;
    $rose(asleep) && pin_hist_ff == 5'h00 && !sleep_pin
      |-> !$past(int_pending) && $past(int_enable_reg[4]);
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("sleep entered early");
  property p_wake_mask;
    !fifo_ctrl_reg[3] && !$past(fifo_ctrl_reg[3]) |-> !wake_int;
  endproperty
  a_wake_mask: assert property (p_wake_mask) else $error("wake int unmasked");
  property p_md_drop;
    md && !enhanced_func_reg[5] && rx_char_valid && !rx_enabled
      |=> rx_push == $past(rx_char_par) && lsr_int == rx_push && (!rx_push || rx_push_perr);
  endproperty
  a_md_drop: assert property (p_md_drop) else $error("multidrop filter wrong");
  property p_auto_hit;
    md && enhanced_func_reg[5] && rx_char_valid && rx_char_par
      && rx_char == second_stop_char_reg |=> rx_push && rx_push_perr && lsr_int && rx_enabled;
  endproperty
  a_auto_hit: assert property (p_auto_hit) else $error("address match lost");
  property p_addr_send;
    s_addr_send |=> tx_ninth_bit && !sfr_addr_bit;
  endproperty
  a_addr_send: assert property (p_addr_send) else $error("ninth bit wrong");
endmodule : ulm_monitor
bind ulm_top ulm_monitor i_ulm_monitor (.*);
`default_nettype wire

// >>> sim/ulm_station.sv
// remote station: drives the rx line and times infrared pulses
`timescale 1ns/100ps
`default_nettype none
module ulm_station (
  input wire logic mclk,
  input wire logic ir,
  input wire logic start,
  input wire logic tx_pin,
  output logic rx_pin,
  output logic [7:0] pulse_w
);
  int run; // cycles left of a start bit
  int cnt; // length of the current high pulse
  initial begin
    run = 0;
    cnt = 0;
    pulse_w = 8'h00;
    rx_pin = 1'b1;
  end
  // idle at the mode level, start bit is its inverse
  always @(posedge mclk) begin
    if (start) run <= 16;
    else if (run > 0) run <= run - 1;
    rx_pin <= ir ^ (run == 0);
    if (tx_pin) cnt <= cnt + 1;
    else if (cnt > 0) begin
      pulse_w <= cnt[7:0];
      cnt <= 0;
    end
  end
endmodule : ulm_station
`default_nettype wire
